/* rtl/tsf_defs.svh */
// tsf_defs.svh: register offsets, field positions and reset values of the timer status flag block
// assumes: included by bare name from every file that decodes the register map
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH

`define TSF_ADR_W          8
`define TSF_ADR_CH2B_STAT  8'h00
`define TSF_ADR_CH35_STAT  8'h04
`define TSF_ADR_CH2B_MASK  8'h08
`define TSF_ADR_CH35_MASK  8'h0c
`define TSF_ADR_MODE       8'h10

`define TSF_CH2B_W         9
`define TSF_CH2B_OVF_BIT   8
`define TSF_CH35_W         15
`define TSF_CH_STRIDE      5
`define TSF_OVF_OFS        4
`define TSF_REG_D          3

`define TSF_MODE_PWM_LSB   0
`define TSF_MODE_IC_LSB    4

`define TSF_STAT_RST       16'h0000
`define TSF_MASK_RST       16'h0000
`define TSF_MODE_RST       16'h0000
`define TSF_RDAT_RST       32'h0000_0000

`endif

/* rtl/tsf_pkg.sv */
// tsf_pkg: types shared by the timer status flag block
// assumes: tsf_defs.svh carries every number; this package only shapes signals
package tsf_pkg;

	// one timer channel as seen by the flag logic
	typedef struct packed {
		logic [15:0]      count;
		logic [3:0][15:0] general_reg;
		logic [3:0]       capture;
	} tsf_chan_t;

	// one register access: load in the request cycle, commit in the cycle the bus answer is given
	typedef struct packed {
		logic        load;
		logic        commit;
		logic        we;
		logic [7:0]  adr;
		logic [15:0] wmask;
		logic [15:0] wdat;
	} tsf_acc_t;

	typedef enum logic {
		TSF_WB_IDLE,
		TSF_WB_ACK
	} tsf_wb_state_t;

endpackage

/* rtl/tsf_wb_slave.sv */
// tsf_wb_slave: classic wishbone slave front end, answers every access one cycle after the request
// assumes: master holds cyc, stb, address and data until it samples ack
`timescale 1ns/10ps
module tsf_wb_slave (
	input  wire logic              ref_clk_in,
	input  wire logic              reset_in,
	input  wire logic              wb_cyc_in,
	input  wire logic              wb_stb_in,
	input  wire logic              wb_we_in,
	input  wire logic [7:0]        wb_adr_in,
	input  wire logic [3:0]        wb_sel_in,
	input  wire logic [31:0]       wb_dat_in,
	output logic                   wb_ack_out,
	output tsf_pkg::tsf_acc_t      acc_out
);
	typedef struct packed {
		tsf_pkg::tsf_wb_state_t state;
	} tsf_wbs_state_t;

	tsf_wbs_state_t s_q;
	tsf_wbs_state_t s_d;
	logic           req;

	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	assign req = wb_cyc_in & wb_stb_in;

	always_comb begin
		s_d = s_q;
		case (s_q.state)
			tsf_pkg::TSF_WB_IDLE: begin
				if (req) begin
					s_d.state = tsf_pkg::TSF_WB_ACK;
				end
			end
			tsf_pkg::TSF_WB_ACK: begin
				s_d.state = tsf_pkg::TSF_WB_IDLE;
			end
			default: begin
				s_d.state = tsf_pkg::TSF_WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q.state <= tsf_pkg::TSF_WB_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// load snapshots read data; commit is the edge at which the master takes the answer
	assign wb_ack_out     = (s_q.state == tsf_pkg::TSF_WB_ACK) & req;
	assign acc_out.load   = (s_q.state == tsf_pkg::TSF_WB_IDLE) & req;
	assign acc_out.commit = wb_ack_out;
	assign acc_out.we     = wb_we_in;
	assign acc_out.adr    = wb_adr_in;
	assign acc_out.wmask  = lane_mask(wb_sel_in);
	assign acc_out.wdat   = wb_dat_in[15:0];
endmodule

/* rtl/tsf_flag_reg.sv */
// tsf_flag_reg: bank of sticky status flags cleared by read-while-one then write-zero
// assumes: rd_in and wr_in are single-cycle strobes from the bus front end
`timescale 1ns/10ps
module tsf_flag_reg #(
	parameter int W = 9
) (
	input  wire logic          ref_clk_in,
	input  wire logic          reset_in,
	input  wire logic [W-1:0]  set_in,
	input  wire logic          rd_in,
	input  wire logic [W-1:0]  rd_seen_in,
	input  wire logic          wr_in,
	input  wire logic [W-1:0]  wdat_in,
	input  wire logic [W-1:0]  wmask_in,
	output logic      [W-1:0]  flags_out
);
	typedef struct packed {
		logic [W-1:0] flags;
		logic [W-1:0] armed;
	} tsf_fr_state_t;

	tsf_fr_state_t s_q;
	tsf_fr_state_t s_d;
	logic [W-1:0]  clr;

	// refuse widths the 16-bit bus lanes cannot carry
	if (W < 1 || W > 16) begin : g_bad_w
		$error("tsf_flag_reg: W out of range");
	end

	always_comb begin
		s_d = s_q;
		clr = '0;
		// R2 arm on read
		if (rd_in) begin
			s_d.armed = s_q.armed | rd_seen_in;
		end
		// R4 only written zeros clear
		if (wr_in) begin
			clr       = s_q.armed & wmask_in & ~wdat_in;
			s_d.armed = s_q.armed & ~wmask_in;
		end
		// R14 set beats clear
		s_d.flags = (s_q.flags & ~clr) | set_in;
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q.flags <= '0;
			s_q.armed <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_out = s_q.flags;
endmodule

/* rtl/tsf_status_top.sv */
// tsf_status_top: status flags of timer channel 2B and channels 3 to 5, behind a wishbone slave
// assumes: counters, compare and general registers come from the timer datapath on the same clock
// Summary of operation
// R1 - the channel 2B overflow flag sets when its counter wraps from all ones to zero.
// R2 - a flag clears only after software read it as one and then writes zero to it.
// R3 - compare flags 0 to 7 set when the channel 2B counter equals compare registers A to H.
// R4 - writing one to a flag leaves it alone, writing zero clears it.
// R5 - the channel 3-5 status word holds overflow at bits 14, 9, 4 and capture/match D..A below each, reset 0.
// R6 - bit 15 of the channel 3-5 status word reads zero and software writes zero there.
// R7 - the channel 5 overflow flag sets when its counter wraps from all ones to zero.
// R8 - in capture mode the channel 5 register D flag sets when a capture loads the counter into it.
// R9 - in compare mode the channel 5 register D flag sets when the counter equals it.
// R10 - in PWM mode the channel 5 register D flag sets when the counter equals it.
// R11 - the channel 5 register C flag never sets in PWM mode.
// R12 - the channel 4 overflow flag sets when its counter wraps from all ones to zero.
// R13 - in PWM mode the channel 4 register D flag sets when the counter equals it.
// R14 - a set and a clear of one flag in the same cycle leave the flag set.
`timescale 1ns/10ps
`include "tsf_defs.svh"
module tsf_status_top #(
	parameter int NUM_CMP = 8
) (
	input  wire logic                          ref_clk_in,
	input  wire logic                          reset_in,
	input  wire logic                          wb_cyc_in,
	input  wire logic                          wb_stb_in,
	input  wire logic                          wb_we_in,
	input  wire logic [7:0]                    wb_adr_in,
	input  wire logic [3:0]                    wb_sel_in,
	input  wire logic [31:0]                   wb_dat_in,
	output logic      [31:0]                   wb_dat_out,
	output logic                               wb_ack_out,
	input  wire logic [15:0]                   ch2b_counter_in,
	input  wire logic [NUM_CMP-1:0][15:0]      ch2b_compare_reg_in,
	input  tsf_pkg::tsf_chan_t [2:0]           ch_in,
	output logic      [`TSF_CH2B_W-1:0]        ch2b_status_out,
	output logic      [15:0]                   channels_three_to_five_status_out,
	output logic                               irq_out
);
	typedef struct packed {
		logic [15:0]               ch2b_prev_cnt;
		logic [NUM_CMP-1:0]        ch2b_match_prev;
		logic [2:0][15:0]          ch_prev_cnt;
		logic [2:0][3:0]           ch_match_prev;
		logic [15:0]               mask_ch2b;
		logic [15:0]               mask_ch35;
		logic [15:0]               mode;
		logic [31:0]               rdat;
	} tsf_top_state_t;

	tsf_top_state_t              s_q;
	tsf_top_state_t              s_d;
	tsf_pkg::tsf_acc_t           acc;
	logic [NUM_CMP-1:0]          ch2b_match_now;
	logic [`TSF_CH2B_W-1:0]      ch2b_set;
	logic [`TSF_CH2B_W-1:0]      ch2b_flags;
	logic [2:0][3:0]             ch_match_now;
	logic [`TSF_CH35_W-1:0]      ch35_set;
	logic [`TSF_CH35_W-1:0]      ch35_flags;
	logic [15:0]                 ch35_word;
	logic                        rd_ch2b;
	logic                        rd_ch35;
	logic                        wr_ch2b;
	logic                        wr_ch35;

	// only bits 7:0 of the channel 2B word hold compare flags
	if (NUM_CMP < 1 || NUM_CMP > 8) begin : g_bad_cmp
		$error("tsf_status_top: NUM_CMP must be 1 to 8");
	end

	function automatic logic wrapped(input logic [15:0] prev, input logic [15:0] now);
		wrapped = (&prev) & ~(|now);
	endfunction

	function automatic logic hits(input logic [7:0] adr, input logic [7:0] target);
		hits = (adr == target);
	endfunction

	tsf_wb_slave u_wb (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.wb_cyc_in  (wb_cyc_in),
		.wb_stb_in  (wb_stb_in),
		.wb_we_in   (wb_we_in),
		.wb_adr_in  (wb_adr_in),
		.wb_sel_in  (wb_sel_in),
		.wb_dat_in  (wb_dat_in),
		.wb_ack_out (wb_ack_out),
		.acc_out    (acc)
	);

	// channel 2B: equality against each compare register, flagged on the cycle it begins
	generate
		for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp2b
			assign ch2b_match_now[i] = (ch2b_counter_in == ch2b_compare_reg_in[i]);
			// R3 compare match set
			assign ch2b_set[i] = ch2b_match_now[i] & ~s_q.ch2b_match_prev[i];
		end
		for (genvar i = NUM_CMP; i < `TSF_CH2B_OVF_BIT; i++) begin : g_cmp2b_pad
			assign ch2b_set[i] = 1'b0;
		end
	endgenerate

	// R1 ch2b wrap detect
	assign ch2b_set[`TSF_CH2B_OVF_BIT] = wrapped(s_q.ch2b_prev_cnt, ch2b_counter_in);

	// channels 3 to 5: c = 0 is channel 3, c = 2 is channel 5
	generate
		for (genvar c = 0; c < 3; c++) begin : g_ch
			logic pwm;
			assign pwm = s_q.mode[`TSF_MODE_PWM_LSB + c];
			for (genvar r = 0; r < 4; r++) begin : g_reg
				logic ic;
				logic cmp_edge;
				assign ic = s_q.mode[`TSF_MODE_IC_LSB + 4 * c + r];
				assign ch_match_now[c][r] = (ch_in[c].count == ch_in[c].general_reg[r]);
				assign cmp_edge = ch_match_now[c][r] & ~s_q.ch_match_prev[c][r];
				if (r == `TSF_REG_D) begin : g_d
					// R8 capture into d
					// R9 compare on d
					// R10 pwm sync on d
					// R13 ch4 pwm sync
					assign ch35_set[`TSF_CH_STRIDE * c + r] = pwm ? cmp_edge :
						(ic ? ch_in[c].capture[r] : cmp_edge);
				end else begin : g_abc
					// R11 no pwm flag
					assign ch35_set[`TSF_CH_STRIDE * c + r] = ~pwm &
						(ic ? ch_in[c].capture[r] : cmp_edge);
				end
			end
			// R7 ch5 wrap detect
			// R12 ch4 wrap detect
			assign ch35_set[`TSF_CH_STRIDE * c + `TSF_OVF_OFS] = wrapped(s_q.ch_prev_cnt[c], ch_in[c].count);
		end
	endgenerate

	assign rd_ch2b = acc.commit & ~acc.we & hits(acc.adr, `TSF_ADR_CH2B_STAT);
	assign rd_ch35 = acc.commit & ~acc.we & hits(acc.adr, `TSF_ADR_CH35_STAT);
	assign wr_ch2b = acc.commit & acc.we & hits(acc.adr, `TSF_ADR_CH2B_STAT);
	assign wr_ch35 = acc.commit & acc.we & hits(acc.adr, `TSF_ADR_CH35_STAT);

	// R2 read then zero
	tsf_flag_reg #(
		.W (`TSF_CH2B_W)
	) u_flags_ch2b (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.set_in     (ch2b_set),
		.rd_in      (rd_ch2b),
		.rd_seen_in (s_q.rdat[`TSF_CH2B_W-1:0]),
		.wr_in      (wr_ch2b),
		.wdat_in    (acc.wdat[`TSF_CH2B_W-1:0]),
		.wmask_in   (acc.wmask[`TSF_CH2B_W-1:0]),
		.flags_out  (ch2b_flags)
	);

	// R2 read then zero
	tsf_flag_reg #(
		.W (`TSF_CH35_W)
	) u_flags_ch35 (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.set_in     (ch35_set),
		.rd_in      (rd_ch35),
		.rd_seen_in (s_q.rdat[`TSF_CH35_W-1:0]),
		.wr_in      (wr_ch35),
		.wdat_in    (acc.wdat[`TSF_CH35_W-1:0]),
		.wmask_in   (acc.wmask[`TSF_CH35_W-1:0]),
		.flags_out  (ch35_flags)
	);

	// R5 status word layout
	// R6 reserved bit zero
	assign ch35_word = {1'b0, ch35_flags};

	always_comb begin
		s_d = s_q;
		s_d.ch2b_prev_cnt   = ch2b_counter_in;
		s_d.ch2b_match_prev = ch2b_match_now;
		for (int c = 0; c < 3; c++) begin
			s_d.ch_prev_cnt[c]   = ch_in[c].count;
			s_d.ch_match_prev[c] = ch_match_now[c];
		end
		// snapshot read data on the request so the answer comes from a flip-flop
		if (acc.load) begin
			s_d.rdat = `TSF_RDAT_RST;
			if (!acc.we) begin
				if (hits(acc.adr, `TSF_ADR_CH2B_STAT)) begin
					s_d.rdat[`TSF_CH2B_W-1:0] = ch2b_flags;
				end else if (hits(acc.adr, `TSF_ADR_CH35_STAT)) begin
					s_d.rdat[15:0] = ch35_word;
				end else if (hits(acc.adr, `TSF_ADR_CH2B_MASK)) begin
					s_d.rdat[15:0] = s_q.mask_ch2b;
				end else if (hits(acc.adr, `TSF_ADR_CH35_MASK)) begin
					s_d.rdat[15:0] = s_q.mask_ch35;
				end else if (hits(acc.adr, `TSF_ADR_MODE)) begin
					s_d.rdat[15:0] = s_q.mode;
				end
			end
		end
		// plain control registers honour the byte lanes; unused bits stay zero
		if (acc.commit && acc.we) begin
			if (hits(acc.adr, `TSF_ADR_CH2B_MASK)) begin
				s_d.mask_ch2b = ((s_q.mask_ch2b & ~acc.wmask) | (acc.wdat & acc.wmask)) &
					{{(16 - `TSF_CH2B_W){1'b0}}, {`TSF_CH2B_W{1'b1}}};
			end else if (hits(acc.adr, `TSF_ADR_CH35_MASK)) begin
				s_d.mask_ch35 = ((s_q.mask_ch35 & ~acc.wmask) | (acc.wdat & acc.wmask)) &
					{{(16 - `TSF_CH35_W){1'b0}}, {`TSF_CH35_W{1'b1}}};
			end else if (hits(acc.adr, `TSF_ADR_MODE)) begin
				s_d.mode = ((s_q.mode & ~acc.wmask) | (acc.wdat & acc.wmask)) & 16'hfff7;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q.ch2b_prev_cnt   <= `TSF_STAT_RST;
			s_q.ch2b_match_prev <= '0;
			s_q.ch_prev_cnt     <= '0;
			s_q.ch_match_prev   <= '0;
			s_q.mask_ch2b       <= `TSF_MASK_RST;
			s_q.mask_ch35       <= `TSF_MASK_RST;
			s_q.mode            <= `TSF_MODE_RST;
			s_q.rdat            <= `TSF_RDAT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_out                        = s_q.rdat;
	assign ch2b_status_out                   = ch2b_flags;
	assign channels_three_to_five_status_out = ch35_word;
	assign irq_out = (|(ch2b_flags & s_q.mask_ch2b[`TSF_CH2B_W-1:0])) |
		(|(ch35_flags & s_q.mask_ch35[`TSF_CH35_W-1:0]));
endmodule

/* dv/tsf_status_asserts.sv */
// tsf_status_asserts: port-level checks of the timer status flag block
// assumes: bound to tsf_status_top, one clock, async active high reset
`timescale 1ns/10ps
`include "tsf_defs.svh"
module tsf_status_asserts #(
	parameter int NUM_CMP = 8
) (
	input wire logic                     ref_clk_in,
	input wire logic                     reset_in,
	input wire logic                     wb_cyc_in,
	input wire logic                     wb_stb_in,
	input wire logic                     wb_we_in,
	input wire logic [7:0]               wb_adr_in,
	input wire logic [3:0]               wb_sel_in,
	input wire logic [31:0]              wb_dat_in,
	input wire logic [31:0]              wb_dat_out,
	input wire logic                     wb_ack_out,
	input wire logic [15:0]              ch2b_counter_in,
	input wire logic [NUM_CMP-1:0][15:0] ch2b_compare_reg_in,
	input tsf_pkg::tsf_chan_t [2:0]      ch_in,
	input wire logic [`TSF_CH2B_W-1:0]   ch2b_status_out,
	input wire logic [15:0]              channels_three_to_five_status_out,
	input wire logic                     irq_out
);
	default clocking dcb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	sequence req_s;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	// history is cleared by reset, so a wrap straddling reset is not an event
	sequence wrap_s(logic [15:0] c);
		!$past(reset_in) && $past(c) == 16'hffff && c == 16'h0000;
	endsequence
	ack_once_a: assert property (req_s |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not a single pulse");
	ch2b_overflow_flag_set_a: assert property (wrap_s(ch2b_counter_in) |=> ch2b_status_out[8])
		else $error("ch2b overflow flag not set");
	match_a_set_a: assert property ((ch2b_counter_in == ch2b_compare_reg_in[0]) &&
		!$past(ch2b_counter_in == ch2b_compare_reg_in[0]) |=> ch2b_status_out[0]) else $error("match flag a not set");
	match_h_set_a: assert property ((ch2b_counter_in == ch2b_compare_reg_in[7]) &&
		!$past(ch2b_counter_in == ch2b_compare_reg_in[7]) |=> ch2b_status_out[7]) else $error("match flag h not set");
	ch5_overflow_flag_set_a: assert property (wrap_s(ch_in[2].count) |=> channels_three_to_five_status_out[14])
		else $error("ch5 overflow flag not set");
	ch4_overflow_flag_set_a: assert property (wrap_s(ch_in[1].count) |=> channels_three_to_five_status_out[9])
		else $error("ch4 overflow flag not set");
	flag_clear_a: assert property ((|($past(channels_three_to_five_status_out) & ~channels_three_to_five_status_out))
		|-> $past(wb_ack_out && wb_we_in && wb_adr_in == 8'h04)) else $error("flag fell without a write");
	write_one_a: assert property (wb_ack_out && wb_we_in && wb_adr_in == 8'h00 |=>
		($past(ch2b_status_out) & $past(wb_dat_in[8:0]) & ~ch2b_status_out) == 9'h000) else $error("write one cleared");
	top_bit_zero_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h04 |-> wb_dat_out[31:15] == 17'h00000)
		else $error("reserved read bits not zero");
endmodule

bind tsf_status_top tsf_status_asserts #(.NUM_CMP(NUM_CMP)) i_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
	.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .ch2b_counter_in(ch2b_counter_in),
	.ch2b_compare_reg_in(ch2b_compare_reg_in), .ch_in(ch_in), .ch2b_status_out(ch2b_status_out),
	.channels_three_to_five_status_out(channels_three_to_five_status_out), .irq_out(irq_out));

/* dv/tsf_status_top_tb.sv */
// tsf_status_top_tb: self-checking bench of the timer status flag block
// assumes: wishbone answer within a few cycles, reads scored from a queue
`timescale 1ns/10ps
module tsf_status_top_tb;
	logic                     clk, rst, cyc, stb, we, ack, irq;
	logic [7:0]               adr;
	logic [3:0]               sel;
	logic [31:0]              dw, dr, seed;
	logic [15:0]              cnt, st35;
	logic [8:0]               st2b;
	logic [7:0][15:0]         cmp;
	tsf_pkg::tsf_chan_t [2:0] ch;
	logic [31:0]              q[$];
	logic [7:0]               ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
	logic [15:0]              rb[3] = '{16'h01ff, 16'h7fff, 16'hfff7};
	int                       n_errors = 0;
	int                       total_checks = 0;

	tsf_status_top i_dut (.ref_clk_in(clk), .reset_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(ack),
		.ch2b_counter_in(cnt), .ch2b_compare_reg_in(cmp), .ch_in(ch), .ch2b_status_out(st2b),
		.channels_three_to_five_status_out(st35), .irq_out(irq));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic complete_run();
		if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected read data expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_irq(input logic e);
		@(negedge clk);
		total_checks++;
		if (irq !== e) begin
			n_errors++;
			$display("unexpected irq expected %b seen %b", e, irq);
		end
		@(posedge clk);
	endtask

	// request held until ack is sampled, then released for a cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		q.push_back({16'h0000, e});
		bus(1'b0, a, 16'h0000);
	endtask

	task automatic step();
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			cmp_rd((q.size() > 0) ? q.pop_front() : 32'hxxxxxxxx, dr);
		end
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	initial begin
		logic [31:0] r;
		rst = 1'b1;
		{cyc, stb, we, adr, dw} = '0;
		sel = 4'h3;
		cnt = 16'h0001;
		ch = '0;
		seed = 32'hb478;
		// distinct top nibbles keep compare values apart and never all ones
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			cmp[i] = {4'(i + 1), r[11:0]};
		end
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 4; k++) begin
				r = rnd();
				ch[c].general_reg[k] = {4'(9 + c), 2'(k), r[9:0]};
			end
		end
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i]) rd(ra[i], 16'h0000);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, ra[i + 2], 16'hffff);
			rd(ra[i + 2], rb[i]);
			bus(1'b1, ra[i + 2], 16'h0000);
		end
		bus(1'b1, 8'h20, 16'hffff);
		rd(8'h20, 16'h0000);
		cnt <= 16'hffff;
		step();
		cnt <= 16'h0000;
		step();
		foreach (cmp[i]) begin
			cnt <= cmp[i];
			step();
			cnt <= 16'h0001;
			step();
		end
		cmp_irq(1'b0);
		bus(1'b1, 8'h08, 16'h0001);
		cmp_irq(1'b1);
		bus(1'b1, 8'h00, 16'h0000);
		rd(8'h00, 16'h01ff);
		bus(1'b1, 8'h00, 16'h00ff);
		rd(8'h00, 16'h00ff);
		// match event lands in the ack cycle of the clearing write
		fork
			bus(1'b1, 8'h00, 16'h0000);
			begin
				step();
				cnt <= cmp[0];
				step();
				cnt <= 16'h0001;
			end
		join
		rd(8'h00, 16'h0001);
		cmp_irq(1'b1);
		bus(1'b1, 8'h00, 16'h0000);
		rd(8'h00, 16'h0000);
		cmp_irq(1'b0);
		foreach (ch[c]) ch[c].count <= 16'hffff;
		step();
		foreach (ch[c]) ch[c].count <= 16'h0000;
		step();
		rd(8'h04, 16'h4210);
		bus(1'b1, 8'h04, 16'h0000);
		bus(1'b1, 8'h10, 16'h8000);
		ch[2].capture <= 4'b1100;
		step();
		ch[2].capture <= 4'b0000;
		step();
		rd(8'h04, 16'h2000);
		bus(1'b1, 8'h04, 16'h0000);
		bus(1'b1, 8'h10, 16'h0000);
		ch[2].count <= ch[2].general_reg[3];
		step();
		ch[2].count <= 16'h0000;
		step();
		rd(8'h04, 16'h2000);
		bus(1'b1, 8'h04, 16'h0000);
		bus(1'b1, 8'h10, 16'h0006);
		ch[2].count <= ch[2].general_reg[2];
		step();
		ch[2].count <= ch[2].general_reg[3];
		ch[1].count <= ch[1].general_reg[3];
		step();
		foreach (ch[c]) ch[c].count <= 16'h0000;
		step();
		rd(8'h04, 16'h2100);
		complete_run();
	end
endmodule
